//--- include/serial_front_pkg.sv
// constants and types for the serial front end
package serial_front_pkg;
  localparam int unsigned CLOCK_HZ        = 200000000;
  localparam int unsigned FALLBACK_BAUD   = 300;
  localparam int unsigned BAUD_DIV_W      = 20;
  localparam logic [BAUD_DIV_W-1:0] FALLBACK_DIV = BAUD_DIV_W'(CLOCK_HZ / FALLBACK_BAUD);
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES = CLOCK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned RESET_PULSE_CYCLES = 16;
  // factory setup
  localparam logic [7:0] FACTORY_ADDR     = 8'h31;
  localparam logic [3:0] FACTORY_BAUD     = 4'h0;
  localparam logic [1:0] FACTORY_PARITY   = 2'h0;
  localparam logic       FACTORY_LINEFEED = 1'b0;
  localparam logic       FACTORY_ALARM    = 1'b0;
  localparam logic [1:0] FACTORY_DELAY    = 2'h2;
  localparam logic       FACTORY_RTU      = 1'b0;
  // parity codes
  localparam logic [1:0] PARITY_NONE      = 2'h0;
  // reserved address codes, then reply framing characters and lengths
  localparam logic [7:0] CHAR_NULL        = 8'h00;
  localparam logic [7:0] CHAR_CR          = 8'h0D;
  localparam logic [7:0] CHAR_DOLLAR      = 8'h24;
  localparam logic [7:0] CHAR_HASH        = 8'h23;
  localparam logic [7:0] CHAR_LBRACE      = 8'h7B;
  localparam logic [7:0] CHAR_RBRACE      = 8'h7D;
  localparam logic [7:0] CHAR_STAR        = 8'h2A;
  localparam logic [7:0] CHAR_PLUS        = 8'h2B;
  localparam logic [7:0] CHAR_MINUS       = 8'h2D;
  localparam logic [7:0] CHAR_DOT         = 8'h2E;
  localparam logic [7:0] CHAR_ZERO        = 8'h30;
  localparam int unsigned READ_REPLY_LEN  = 10;
  localparam int unsigned DIGITS          = 7;
  typedef enum logic [2:0] {
    CMD_NONE          = 3'h0,
    CMD_DATA_READ     = 3'h1,
    CMD_SETUP_READ    = 3'h2,
    CMD_SETUP_WRITE   = 3'h3,
    CMD_RTU_ENABLE    = 3'h4,
    CMD_RTU_DISABLE   = 3'h5,
    CMD_OTHER         = 3'h6
  } cmd_t;
  typedef enum logic [1:0] {
    RD_IDLE  = 2'h0,
    RD_SEND  = 2'h1,
    RD_WAIT  = 2'h2
  } reply_state_t;
endpackage

//--- rtl/strap_conditioner.sv
// synchroniser and debouncer for the fallback strap
`timescale 1ns/1ps
`default_nettype none
module strap_conditioner #(
  parameter int unsigned DEBOUNCE_CYCLES = serial_front_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic strapPin_n,
  output logic      strapActive,
  output logic      strapReleased
);
  localparam int unsigned CW = $clog2(DEBOUNCE_CYCLES + 1);
  logic [2:0]    sync_r;
  logic [CW-1:0] count_r;
  logic          stable_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_r <= 3'h7;
    end else begin
      sync_r <= {sync_r[1:0], strapPin_n};
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r  <= '0;
      stable_r <= 1'b1;
    end else if ((sync_r[1] == sync_r[2]) && (sync_r[2] != stable_r)) begin
      if (count_r == CW'(DEBOUNCE_CYCLES - 1)) begin
        stable_r <= sync_r[2];
        count_r  <= '0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end else begin
      count_r <= '0;
    end
  end
  assign strapActive = ~stable_r;
  // one pulse per debounced release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strapReleased <= 1'b0;
    end else begin
      strapReleased <= (sync_r[1] == sync_r[2]) && sync_r[2] && !stable_r
                       && (count_r == CW'(DEBOUNCE_CYCLES - 1));
    end
  end
endmodule
`default_nettype wire

//--- rtl/default_mode_serial_front_end.sv
// serial front end with fallback setup, address decode and reply framing
// How it works
// - strap grounded forces 300 baud 8N1
// - strap never alters stored setup values
// - every command accepted in fallback mode, bar the six reserved address codes
// - four distinct channels, all enabled in fallback
// - addresses are four consecutive codes from stored first
// - fallback answers all but six reserved codes while rtu protocol is not active
// - setup readback reports stored values and address
// - fallback unmatched address selects channel zero
// - setup write stores, link stays fallback
// - strap release triggers program reset, stored setup
// - read reply: asterisk, sign, seven digits, point
// - factory setup: address 1, 300 baud, defaults
// - rtu enable/disable commands select protocol
// - protocol change takes effect after reset
`timescale 1ns/1ps
`default_nettype none
module default_mode_serial_front_end #(
  parameter int unsigned DEBOUNCE_CYCLES = serial_front_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        strapPin_n,
  input  wire logic        cmdValid,
  input  wire serial_front_pkg::cmd_t cmdKind,
  input  wire logic [7:0]  cmdAddr,
  input  wire logic [7:0]  wrFirstAddr,
  input  wire logic [3:0]  wrBaudCode,
  input  wire logic [1:0]  wrParity,
  input  wire logic        wrLinefeed,
  input  wire logic        wrAlarm,
  input  wire logic [1:0]  wrDelay,
  input  wire logic        readingNeg,
  input  wire logic [27:0] readingBcd,
  input  wire logic [2:0]  readingPoint,
  input  wire logic [serial_front_pkg::BAUD_DIV_W-1:0] storedBaudDiv,
  output logic             cmdAccept,
  output logic             cmdExecute,
  output logic [1:0]       channelSel,
  output logic [3:0]       channelEnable,
  output logic             fallbackMode,
  output logic [serial_front_pkg::BAUD_DIV_W-1:0] activeBaudDiv,
  output logic [1:0]       activeParity,
  output logic             rtuActive,
  output logic             programReset,
  output logic [7:0]       setupFirstAddr,
  output logic [3:0]       setupBaudCode,
  output logic [1:0]       setupParity,
  output logic             setupLinefeed,
  output logic             setupAlarm,
  output logic [1:0]       setupDelay,
  output logic             setupRtu,
  output logic             setupReport,
  output logic             replyValid,
  output logic [7:0]       replyChar,
  input  wire logic        replyReady
);
  localparam int unsigned BAUD_W = serial_front_pkg::BAUD_DIV_W;
  localparam int unsigned RPW = $clog2(serial_front_pkg::RESET_PULSE_CYCLES + 1);

  logic strapActive;
  logic strapReleased;
  strap_conditioner #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_strap (
    .clock         (clock),
    .reset_n       (reset_n),
    .strapPin_n    (strapPin_n),
    .strapActive   (strapActive),
    .strapReleased (strapReleased)
  );

  function automatic logic isReserved(input logic [7:0] c);
    isReserved = (c == serial_front_pkg::CHAR_NULL) || (c == serial_front_pkg::CHAR_CR)
              || (c == serial_front_pkg::CHAR_DOLLAR) || (c == serial_front_pkg::CHAR_HASH)
              || (c == serial_front_pkg::CHAR_LBRACE) || (c == serial_front_pkg::CHAR_RBRACE);
  endfunction

  // program reset pulse on strap release
  logic [RPW-1:0] rstCount_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstCount_r <= '0;
    end else if (strapReleased) begin
      rstCount_r <= RPW'(serial_front_pkg::RESET_PULSE_CYCLES);
    end else if (rstCount_r != '0) begin
      rstCount_r <= rstCount_r - 1'b1;
    end
  end
  assign programReset = (rstCount_r != '0);
  assign fallbackMode = strapActive;

  // stored setup, written only by setup write and rtu commands
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      setupFirstAddr <= serial_front_pkg::FACTORY_ADDR;
      setupBaudCode  <= serial_front_pkg::FACTORY_BAUD;
      setupParity    <= serial_front_pkg::FACTORY_PARITY;
      setupLinefeed  <= serial_front_pkg::FACTORY_LINEFEED;
      setupAlarm     <= serial_front_pkg::FACTORY_ALARM;
      setupDelay     <= serial_front_pkg::FACTORY_DELAY;
      setupRtu       <= serial_front_pkg::FACTORY_RTU;
    end else if (cmdExecute) begin
      // strap state never writes here
      unique case (cmdKind)
        serial_front_pkg::CMD_SETUP_WRITE: begin
          setupFirstAddr <= wrFirstAddr;
          setupBaudCode  <= wrBaudCode;
          setupParity    <= wrParity;
          setupLinefeed  <= wrLinefeed;
          setupAlarm     <= wrAlarm;
          setupDelay     <= wrDelay;
        end
        serial_front_pkg::CMD_RTU_ENABLE:  setupRtu <= 1'b1;
        serial_front_pkg::CMD_RTU_DISABLE: setupRtu <= 1'b0;
        default: ;
      endcase
    end
  end

  // active link setup: baud/parity latched at reset, protocol too
  logic [BAUD_W-1:0] liveDiv_r;
  logic [1:0]        liveParity_r;
  logic              loadLive_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      loadLive_r <= 1'b1;
    end else begin
      loadLive_r <= programReset;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      liveDiv_r    <= serial_front_pkg::FALLBACK_DIV;
      liveParity_r <= serial_front_pkg::PARITY_NONE;
      rtuActive    <= 1'b0;
    end else if (loadLive_r) begin
      liveDiv_r    <= storedBaudDiv;
      liveParity_r <= setupParity;
      rtuActive    <= setupRtu;
    end
  end
  assign activeBaudDiv = strapActive ? serial_front_pkg::FALLBACK_DIV : liveDiv_r;
  assign activeParity  = strapActive ? serial_front_pkg::PARITY_NONE : liveParity_r;

  // address decode
  logic [7:0] addrOffset;
  logic       addrMatch;
  assign addrOffset = cmdAddr - setupFirstAddr;
  assign addrMatch  = (addrOffset < 8'h04);
  // host always sends an address, so the slot is parsed either way
  assign cmdAccept  = cmdValid && !isReserved(cmdAddr)
                      && (strapActive || addrMatch);
  assign cmdExecute = cmdAccept && !rtuActive && (cmdKind != serial_front_pkg::CMD_NONE);
  assign channelEnable = strapActive ? 4'hF : 4'hF;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      channelSel <= 2'h0;
    end else if (cmdExecute) begin
      channelSel <= addrMatch ? addrOffset[1:0] : 2'h0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      setupReport <= 1'b0;
    end else begin
      setupReport <= cmdExecute && (cmdKind == serial_front_pkg::CMD_SETUP_READ);
    end
  end

  // data read reply: '*', sign, seven digits, decimal point inserted
  serial_front_pkg::reply_state_t rdState_r;
  logic [3:0]  rdIdx_r;
  logic [27:0] bcd_r;
  logic        neg_r;
  logic [2:0]  point_r;
  logic [3:0]  digitPos;
  logic [3:0]  digitVal;
  logic [7:0]  charNxt;
  always_comb begin
    digitPos = 4'h0;
    digitVal = 4'h0;
    charNxt  = serial_front_pkg::CHAR_STAR;
    if (rdIdx_r == 4'h0) begin
      charNxt = serial_front_pkg::CHAR_STAR;
    end else if (rdIdx_r == 4'h1) begin
      charNxt = neg_r ? serial_front_pkg::CHAR_MINUS : serial_front_pkg::CHAR_PLUS;
    end else if (rdIdx_r == 4'(2 + {1'b0, point_r})) begin
      charNxt = serial_front_pkg::CHAR_DOT;
    end else begin
      digitPos = (rdIdx_r > 4'(2 + {1'b0, point_r})) ? rdIdx_r - 4'h3 : rdIdx_r - 4'h2;
      digitVal = bcd_r[27 - 4 * digitPos -: 4];
      charNxt  = serial_front_pkg::CHAR_ZERO + {4'h0, digitVal};
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdState_r  <= serial_front_pkg::RD_IDLE;
      rdIdx_r    <= 4'h0;
      bcd_r      <= '0;
      neg_r      <= 1'b0;
      point_r    <= 3'h0;
      replyValid <= 1'b0;
      replyChar  <= 8'h00;
    end else begin
      unique case (rdState_r)
        serial_front_pkg::RD_IDLE: begin
          if (cmdExecute && (cmdKind == serial_front_pkg::CMD_DATA_READ)) begin
            bcd_r     <= readingBcd;
            neg_r     <= readingNeg;
            point_r   <= (readingPoint > 3'(serial_front_pkg::DIGITS)) ?
                         3'(serial_front_pkg::DIGITS) : readingPoint;
            rdIdx_r   <= 4'h0;
            rdState_r <= serial_front_pkg::RD_SEND;
          end
        end
        serial_front_pkg::RD_SEND: begin
          replyChar  <= charNxt;
          replyValid <= 1'b1;
          rdState_r  <= serial_front_pkg::RD_WAIT;
        end
        serial_front_pkg::RD_WAIT: begin
          if (replyReady) begin
            replyValid <= 1'b0;
            if (rdIdx_r == 4'(serial_front_pkg::READ_REPLY_LEN - 1)) begin
              rdState_r <= serial_front_pkg::RD_IDLE;
            end else begin
              rdIdx_r   <= rdIdx_r + 1'b1;
              rdState_r <= serial_front_pkg::RD_SEND;
            end
          end
        end
        default: rdState_r <= serial_front_pkg::RD_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tb/default_mode_serial_front_end_properties.sv
// checker for the serial front end ports
`timescale 1ns/1ps
`default_nettype none
module serial_front_checker (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic                   cmdValid,
  input wire serial_front_pkg::cmd_t cmdKind,
  input wire logic [7:0]             cmdAddr,
  input wire logic [7:0]             wrFirstAddr,
  input wire logic                   cmdAccept,
  input wire logic                   cmdExecute,
  input wire logic [1:0]             channelSel,
  input wire logic [3:0]             channelEnable,
  input wire logic                   fallbackMode,
  input wire logic [19:0]            activeBaudDiv,
  input wire logic [1:0]             activeParity,
  input wire logic                   rtuActive,
  input wire logic                   programReset,
  input wire logic [7:0]             setupFirstAddr,
  input wire logic                   setupReport,
  input wire logic                   replyValid,
  input wire logic [7:0]             replyChar,
  input wire logic                   replyReady
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] offs;
  logic       rsvd;
  logic       rd;
  assign offs = cmdAddr - setupFirstAddr;
  assign rsvd = cmdAddr inside {8'h00, 8'h0D, 8'h24, 8'h23, 8'h7B, 8'h7D};
  assign rd   = cmdExecute && cmdKind == serial_front_pkg::CMD_DATA_READ;
  fallback_link_a: assert property (fallbackMode |->
    activeBaudDiv == serial_front_pkg::FALLBACK_DIV && activeParity == 2'h0)
    else $error("fallback link setting wrong");
  all_enabled_a: assert property (channelEnable == 4'hF)
    else $error("channel enables wrong");
  reserved_refused_a: assert property (cmdValid && rsvd |-> !cmdAccept)
    else $error("reserved address accepted");
  fallback_any_a: assert property (fallbackMode && cmdValid && !rsvd |-> cmdAccept)
    else $error("fallback command refused");
  chan_offset_a: assert property (rd && offs < 8'h04 |=> {6'h00, channelSel} == $past(offs))
    else $error("channel select wrong");
  fallback_chan0_a: assert property (rd && fallbackMode && offs > 8'h03 |=> channelSel == 2'h0)
    else $error("unmatched address not channel zero");
  readback_pulse_a: assert property (
    cmdExecute && cmdKind == serial_front_pkg::CMD_SETUP_READ |=> setupReport)
    else $error("setup report missing");
  reply_star_a: assert property (rd && !replyValid && !$past(replyValid) && !$past(rd)
    |-> ##2 replyValid && replyChar == 8'h2A)
    else $error("reply does not start with asterisk");
  reply_hold_a: assert property (replyValid && !replyReady |=> replyValid && $stable(replyChar))
    else $error("reply character dropped");
  rtu_refuse_a: assert property (rtuActive |-> !cmdExecute)
    else $error("command run in rtu protocol");
  rtu_latched_a: assert property (
    !programReset && !$past(programReset) && !$past(programReset, 2) |-> $stable(rtuActive))
    else $error("protocol changed without reset");
  reset_pulse_a: assert property ($rose(programReset) |-> programReset [*8])
    else $error("program reset too short");
  pulse_once_a: assert property ($fell(programReset) |-> !programReset [*8])
    else $error("program reset repeated");
  setup_store_a: assert property (
    cmdExecute && cmdKind == serial_front_pkg::CMD_SETUP_WRITE |=> setupFirstAddr == $past(wrFirstAddr))
    else $error("setup write not stored");
  cover property (rd && fallbackMode);
  cover property ($rose(programReset));
  cover property (replyValid && !replyReady);
endmodule
bind default_mode_serial_front_end serial_front_checker u_serial_front_checker (
  .clock, .reset_n, .cmdValid, .cmdKind, .cmdAddr, .wrFirstAddr, .cmdAccept, .cmdExecute,
  .channelSel, .channelEnable, .fallbackMode, .activeBaudDiv, .activeParity, .rtuActive,
  .programReset, .setupFirstAddr, .setupReport, .replyValid, .replyChar, .replyReady);
`default_nettype wire

//--- tb/host_terminal_model.sv
// host terminal model taking reply characters
`timescale 1ns/1ps
`default_nettype none
module host_terminal_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       slow,
  input  wire logic       replyValid,
  input  wire logic [7:0] replyChar,
  output logic            replyReady
);
  logic [7:0] rxBuf [16];
  logic [4:0] rxCount;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      replyReady <= 1'b0;
      rxCount    <= 5'h00;
    end else begin
      replyReady <= slow ? ~replyReady : 1'b1;
      if (replyValid && replyReady) begin
        rxBuf[rxCount[3:0]] <= replyChar;
        rxCount             <= rxCount + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_default_mode_serial_front_end.sv
// self-checking bench for the serial front end
`timescale 1ns/1ps
`default_nettype none
module tb_default_mode_serial_front_end;
  logic clock, reset_n, strapPin_n, cmdValid, slow, acc, ex;
  serial_front_pkg::cmd_t cmdKind;
  logic [7:0]  cmdAddr, wrFirstAddr, setupFirstAddr, replyChar;
  logic [3:0]  wrBaudCode, channelEnable, setupBaudCode;
  logic [1:0]  wrParity, wrDelay, channelSel, activeParity, setupParity, setupDelay;
  logic        wrLinefeed, wrAlarm, readingNeg, cmdAccept, cmdExecute, fallbackMode;
  logic        rtuActive, programReset, setupLinefeed, setupAlarm, setupRtu, setupReport;
  logic        replyValid, replyReady;
  logic [27:0] readingBcd;
  logic [2:0]  readingPoint;
  logic [19:0] storedBaudDiv, activeBaudDiv;
  logic [7:0]  rsv [6] = '{8'h00, 8'h0D, 8'h24, 8'h23, 8'h7B, 8'h7D};
  int          failCount, checksDone;
  default_mode_serial_front_end #(.DEBOUNCE_CYCLES(4)) u_default_mode_serial_front_end (
    .clock, .reset_n, .strapPin_n, .cmdValid, .cmdKind, .cmdAddr, .wrFirstAddr, .wrBaudCode,
    .wrParity, .wrLinefeed, .wrAlarm, .wrDelay, .readingNeg, .readingBcd, .readingPoint,
    .storedBaudDiv, .cmdAccept, .cmdExecute, .channelSel, .channelEnable, .fallbackMode,
    .activeBaudDiv, .activeParity, .rtuActive, .programReset, .setupFirstAddr, .setupBaudCode,
    .setupParity, .setupLinefeed, .setupAlarm, .setupDelay, .setupRtu, .setupReport,
    .replyValid, .replyChar, .replyReady);
  host_terminal_model u_host_terminal_model (
    .clock, .reset_n, .slow, .replyValid, .replyChar, .replyReady);
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input serial_front_pkg::cmd_t k, input logic [7:0] a);
    @(posedge clock);
    #1;
    cmdValid = 1'b1;
    cmdKind  = k;
    cmdAddr  = a;
    #1;
    acc = cmdAccept;
    ex  = cmdExecute;
    @(posedge clock);
    #1;
    cmdValid = 1'b0;
  endtask
  task automatic wait_on(input bit pr, input logic want);
    int n;
    n = 0;
    while ((pr ? programReset : fallbackMode) !== want && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(pr ? programReset : fallbackMode, want);
  endtask
  task automatic read_reply(input logic [7:0] a, input string s);
    int base, n;
    base = u_host_terminal_model.rxCount;
    n = 0;
    cmd(serial_front_pkg::CMD_DATA_READ, a);
    while (u_host_terminal_model.rxCount != base + 10 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    for (int i = 0; i < 10; i++) chk(u_host_terminal_model.rxBuf[(base + i) % 16], s[i]);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200000;
    failCount++;
    end_of_test();
  end
  initial begin
    {failCount, checksDone, reset_n, cmdValid, slow, readingNeg} = '0;
    {wrLinefeed, wrAlarm} = 2'b11;
    cmdKind = serial_front_pkg::CMD_NONE;
    {strapPin_n, cmdAddr, wrFirstAddr, wrBaudCode} = {1'b1, 8'h00, 8'h30, 4'h3};
    {wrParity, wrDelay, readingBcd, readingPoint} = {2'h1, 2'h1, 28'h0002500, 3'h5};
    storedBaudDiv = 20'h01234;
    repeat (20) @(posedge clock);
    #1 reset_n = 1'b1;
    @(posedge clock);
    #1;
    chk({setupFirstAddr, setupBaudCode, setupParity, setupLinefeed, setupAlarm, setupDelay,
         setupRtu}, {8'h31, 4'h0, 2'h0, 2'h0, 2'h2, 1'b0});
    read_reply(8'h33, "*+00025.00");
    chk(channelSel, 2'h2);
    for (int i = 0; i < 4; i++) begin
      cmd(serial_front_pkg::CMD_OTHER, 8'h31 + i[7:0]);
      chk({acc, channelSel}, {1'b1, i[1:0]});
    end
    cmd(serial_front_pkg::CMD_OTHER, 8'h35);
    chk(acc, 1'b0);
    {slow, readingNeg, readingBcd, readingPoint} = {2'b11, 28'h1234567, 3'h3};
    read_reply(8'h31, "*-123.4567");
    strapPin_n = 1'b0;
    wait_on(1'b0, 1'b1);
    chk({activeBaudDiv, activeParity}, {serial_front_pkg::FALLBACK_DIV, 2'h0});
    chk({channelEnable, setupFirstAddr, setupParity}, {4'hF, 8'h31, 2'h0});
    foreach (rsv[i]) begin
      cmd(serial_front_pkg::CMD_OTHER, rsv[i]);
      chk(acc, 1'b0);
    end
    cmd(serial_front_pkg::CMD_OTHER, 8'h34);
    chk({acc, channelSel}, 3'h7);
    slow = 1'b0;
    read_reply(8'h41, "*-123.4567");
    chk(channelSel, 2'h0);
    cmd(serial_front_pkg::CMD_SETUP_WRITE, 8'h7A);
    chk({ex, setupFirstAddr, setupParity, activeParity}, {1'b1, 8'h30, 2'h1, 2'h0});
    chk(activeBaudDiv, serial_front_pkg::FALLBACK_DIV);
    cmd(serial_front_pkg::CMD_SETUP_READ, 8'h7A);
    chk({ex, setupReport, setupBaudCode, setupLinefeed, setupAlarm, setupDelay},
        {2'b11, 4'h3, 2'b11, 2'h1});
    cmd(serial_front_pkg::CMD_RTU_ENABLE, 8'h7A);
    chk({ex, setupRtu, rtuActive}, 3'b110);
    cmd(serial_front_pkg::CMD_RTU_DISABLE, 8'h7A);
    chk({ex, setupRtu}, 2'b10);
    cmd(serial_front_pkg::CMD_RTU_ENABLE, 8'h7A);
    strapPin_n = 1'b1;
    wait_on(1'b1, 1'b1);
    wait_on(1'b1, 1'b0);
    @(posedge clock);
    #1;
    chk({activeBaudDiv, activeParity, rtuActive}, {20'h01234, 2'h1, 1'b1});
    cmd(serial_front_pkg::CMD_DATA_READ, 8'h30);
    chk({ex, fallbackMode}, 2'b00);
    end_of_test();
  end
endmodule
`default_nettype wire
